// ==== verilog/crsfb_pkg.sv ====
// Purpose : shared constants and types for the cpu register set
// Assumes : 32-bit words, single core clock, AHB-Lite debug/software access
// Notes   : register window offsets are byte addresses inside the slave
package crsfb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int WORD_W  = 32;
  localparam int ACC_W   = 64;
  localparam int GPR_NUM = 16;
  localparam int IDX_W   = 4;
  localparam int VEC_W   = 8;
  localparam int OFF_W   = 8;

  // ----------------------------------------------------------------
  // register window offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [OFF_W-1:0] OFF_PSW   = 8'h00;
  localparam logic [OFF_W-1:0] OFF_PC    = 8'h04;
  localparam logic [OFF_W-1:0] OFF_VTB   = 8'h08;
  localparam logic [OFF_W-1:0] OFF_FIT   = 8'h0C;
  localparam logic [OFF_W-1:0] OFF_ISP   = 8'h10;
  localparam logic [OFF_W-1:0] OFF_USP   = 8'h14;
  localparam logic [OFF_W-1:0] OFF_SPC   = 8'h18;
  localparam logic [OFF_W-1:0] OFF_SSW   = 8'h1C;
  localparam logic [OFF_W-1:0] OFF_ACCHI = 8'h20;
  localparam logic [OFF_W-1:0] OFF_ACCLO = 8'h24;
  localparam logic [OFF_W-1:0] OFF_ACCMI = 8'h28;

  // ----------------------------------------------------------------
  // fields, reset values, bus codes
  // ----------------------------------------------------------------
  localparam int               PSW_USER_BIT = 17;  // stack select bit
  localparam int               ACC_HI_LSB   = 32;
  localparam int               ACC_MID_LSB  = 16;
  localparam int               VEC_SHIFT    = 2;   // vector entries are words
  localparam logic [WORD_W-1:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [ACC_W-1:0]  ACC_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [IDX_W-1:0]  SP_IDX      = 4'h0;
  localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
  localparam logic              HRESP_OKAY  = 1'h0;

  // accumulator commands from execute, gray along none->lo->hi->product
  typedef enum logic [1:0] {
    ACC_NONE    = 2'h0,
    ACC_WR_LO   = 2'h1,
    ACC_WR_HI   = 2'h3,
    ACC_PRODUCT = 2'h2
  } crsfb_acc_op_t;

  typedef struct packed {
    crsfb_acc_op_t     op;
    logic [ACC_W-1:0]  value;
  } crsfb_acc_cmd_t;

  typedef struct packed {
    logic              en;
    logic [IDX_W-1:0]  idx;
    logic [WORD_W-1:0] data;
  } crsfb_gpr_wr_t;

endpackage

// ==== verilog/crsfb_regset.sv ====
// Purpose : programmer-visible register set of a 32-bit cpu core
// Assumes : execute-stage inputs synchronous to clock; AHB-Lite single words
// Notes   : zero-wait-state slave; core-side writes win over bus writes
`timescale 1ns/1ns

module crsfb_regset (
  input  wire logic                           clock,               // core clock
  input  wire logic                           rst,                 // async reset, high
  input  wire logic                           hsel,                // slave select
  input  wire logic [31:0]                    haddr,               // byte address
  input  wire logic [1:0]                     htrans,              // transfer type
  input  wire logic                           hwrite,              // write not read
  input  wire logic [2:0]                     hsize,               // word only
  input  wire logic [31:0]                    hwdata,              // write data
  input  wire logic                           hready,              // bus ready
  output      logic                           hreadyout,           // never stalls
  output      logic                           hresp,               // always okay
  output      logic [31:0]                    hrdata,              // read data
  input  wire logic [crsfb_pkg::IDX_W-1:0]    rd_a_idx,            // operand a select
  output      logic [crsfb_pkg::WORD_W-1:0]   rd_a_data,           // operand a
  input  wire logic [crsfb_pkg::IDX_W-1:0]    rd_b_idx,            // operand b select
  output      logic [crsfb_pkg::WORD_W-1:0]   rd_b_data,           // operand b
  input  wire crsfb_pkg::crsfb_gpr_wr_t       gpr_wr,              // result write
  output      logic [crsfb_pkg::WORD_W-1:0]   stack_ptr,           // active stack pointer
  input  wire logic                           psw_wr_en,           // status update
  input  wire logic [crsfb_pkg::WORD_W-1:0]   psw_wr_data,         // new status
  output      logic [crsfb_pkg::WORD_W-1:0]   processor_status_word, // status word
  input  wire logic                           pc_wr_en,            // next instruction
  input  wire logic [crsfb_pkg::WORD_W-1:0]   pc_wr_data,          // its address
  output      logic [crsfb_pkg::WORD_W-1:0]   instruction_pointer, // executing address
  input  wire logic                           fast_irq_take,       // fast irq, one pulse
  input  wire logic [crsfb_pkg::VEC_W-1:0]    vec_num,             // table vector number
  output      logic [crsfb_pkg::WORD_W-1:0]   vector_fetch_addr,   // table entry address
  output      logic [crsfb_pkg::WORD_W-1:0]   vector_table_base,   // table start
  output      logic [crsfb_pkg::WORD_W-1:0]   fast_irq_target,     // fast irq branch
  input  wire crsfb_pkg::crsfb_acc_cmd_t      acc_cmd,             // accumulator command
  output      logic [crsfb_pkg::WORD_W-1:0]   read_sum_upper,      // acc 63..32
  output      logic [crsfb_pkg::WORD_W-1:0]   read_sum_middle,     // acc 47..16
  output      logic [crsfb_pkg::WORD_W-1:0]   saved_instruction_pointer, // captured pc
  output      logic [crsfb_pkg::WORD_W-1:0]   saved_status_word    // captured status
);
  import crsfb_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] general_regs [1:GPR_NUM-1];
  logic [WORD_W-1:0] interrupt_stack_ptr;
  logic [WORD_W-1:0] user_stack_ptr;
  logic [ACC_W-1:0]  sixty_four_bit_sum_reg;
  logic              dp_write;
  logic [OFF_W-1:0]  dp_addr;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // register zero has no own storage: it is whichever stack pointer is live
  function automatic logic [WORD_W-1:0] read_gpr(input logic [IDX_W-1:0] idx);
    logic [WORD_W-1:0] v;
    v = stack_ptr;
    if (idx != SP_IDX) begin
      v = general_regs[idx];
    end
    return v;
  endfunction

  function automatic logic [WORD_W-1:0] read_window(input logic [OFF_W-1:0] off);
    logic [WORD_W-1:0] v;
    v = WORD_RESET;                    // unmapped reads as zero
    if (off == OFF_PSW) begin
      v = processor_status_word;
    end else if (off == OFF_PC) begin
      v = instruction_pointer;
    end else if (off == OFF_VTB) begin
      v = vector_table_base;
    end else if (off == OFF_FIT) begin
      v = fast_irq_target;
    end else if (off == OFF_ISP) begin
      v = interrupt_stack_ptr;
    end else if (off == OFF_USP) begin
      v = user_stack_ptr;
    end else if (off == OFF_SPC) begin
      v = saved_instruction_pointer;
    end else if (off == OFF_SSW) begin
      v = saved_status_word;
    end else if (off == OFF_ACCHI) begin
      v = read_sum_upper;
    end else if (off == OFF_ACCLO) begin
      v = sixty_four_bit_sum_reg[ACC_HI_LSB-1:0];
    end else if (off == OFF_ACCMI) begin
      v = read_sum_middle;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // zero wait states: read data is fetched in the address phase so it
  // stands from a flip-flop for the whole data phase
  wire               addr_take   = hsel && hready && (htrans == HTRANS_NONSEQ);
  logic [WORD_W-1:0] next_hrdata;

  // the window function reads registers that are not its arguments, so a
  // continuous assignment would go stale; always_comb follows them as well
  always_comb next_hrdata = read_window(haddr[OFF_W-1:0]);

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dp_write <= 1'b0;
      dp_addr  <= '0;
      hrdata   <= WORD_RESET;
    end else if (hready) begin
      dp_write <= addr_take && hwrite;
      dp_addr  <= haddr[OFF_W-1:0];
      if (addr_take && !hwrite) begin
        hrdata <= next_hrdata;
      end
    end
  end

  // bus write strobes, one per writable register, valid in data phase
  wire sw_psw   = dp_write && (dp_addr == OFF_PSW);
  wire sw_pc    = dp_write && (dp_addr == OFF_PC);
  wire sw_vtb   = dp_write && (dp_addr == OFF_VTB);
  wire sw_fit   = dp_write && (dp_addr == OFF_FIT);
  wire sw_isp   = dp_write && (dp_addr == OFF_ISP);
  wire sw_usp   = dp_write && (dp_addr == OFF_USP);
  wire sw_spc   = dp_write && (dp_addr == OFF_SPC);
  wire sw_ssw   = dp_write && (dp_addr == OFF_SSW);
  wire sw_acchi = dp_write && (dp_addr == OFF_ACCHI);
  wire sw_acclo = dp_write && (dp_addr == OFF_ACCLO);

  // ----------------------------------------------------------------
  // general registers and stack pointers
  // ----------------------------------------------------------------
  wire user_sel = processor_status_word[PSW_USER_BIT];
  wire sp_write = gpr_wr.en && (gpr_wr.idx == SP_IDX);

  assign stack_ptr = user_sel ? user_stack_ptr : interrupt_stack_ptr;
  // operand reads must follow register writes, not only index changes
  always_comb rd_a_data = read_gpr(rd_a_idx);
  always_comb rd_b_data = read_gpr(rd_b_idx);

  // a write to register zero lands in the live stack pointer only
  wire [WORD_W-1:0] next_isp = (sp_write && !user_sel) ? gpr_wr.data :
                               sw_isp ? hwdata : interrupt_stack_ptr;
  wire [WORD_W-1:0] next_usp = (sp_write && user_sel) ? gpr_wr.data :
                               sw_usp ? hwdata : user_stack_ptr;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      interrupt_stack_ptr <= WORD_RESET;
      user_stack_ptr      <= WORD_RESET;
    end else begin
      interrupt_stack_ptr <= next_isp;
      user_stack_ptr      <= next_usp;
    end
  end

  // registers one to fifteen, each with its own write decode
  generate
    for (genvar g = 1; g < GPR_NUM; g++) begin : g_gpr
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          general_regs[g] <= WORD_RESET;
        end else if (gpr_wr.en && (gpr_wr.idx == IDX_W'(g))) begin
          general_regs[g] <= gpr_wr.data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // the fast irq redirect beats an execute-stage pc update in the same cycle
  wire [WORD_W-1:0] next_pc  = fast_irq_take ? fast_irq_target :
                               pc_wr_en ? pc_wr_data :
                               sw_pc ? hwdata : instruction_pointer;
  wire [WORD_W-1:0] next_psw = psw_wr_en ? psw_wr_data :
                               sw_psw ? hwdata : processor_status_word;
  // capture beats a software write landing in the same cycle
  wire [WORD_W-1:0] next_spc = fast_irq_take ? instruction_pointer :
                               sw_spc ? hwdata : saved_instruction_pointer;
  wire [WORD_W-1:0] next_ssw = fast_irq_take ? processor_status_word :
                               sw_ssw ? hwdata : saved_status_word;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      instruction_pointer       <= WORD_RESET;
      processor_status_word     <= WORD_RESET;
      saved_instruction_pointer <= WORD_RESET;
      saved_status_word         <= WORD_RESET;
    end else begin
      instruction_pointer       <= next_pc;
      processor_status_word     <= next_psw;
      saved_instruction_pointer <= next_spc;
      saved_status_word         <= next_ssw;
    end
  end

  // table base and fast target change only under software control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      vector_table_base <= WORD_RESET;
      fast_irq_target   <= WORD_RESET;
    end else begin
      if (sw_vtb) begin
        vector_table_base <= hwdata;
      end
      if (sw_fit) begin
        fast_irq_target <= hwdata;
      end
    end
  end

  // vector entries are one word each; wraps at the top of the space
  assign vector_fetch_addr = vector_table_base
                           + (WORD_W'(vec_num) << VEC_SHIFT);

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] next_acc;

  // execute commands win over software writes to either accumulator half
  always_comb begin
    next_acc = sixty_four_bit_sum_reg;
    case (acc_cmd.op)
      ACC_PRODUCT: next_acc = acc_cmd.value;
      ACC_WR_HI:   next_acc[ACC_W-1:ACC_HI_LSB] =
                     acc_cmd.value[ACC_W-1:ACC_HI_LSB];
      ACC_WR_LO:   next_acc[ACC_HI_LSB-1:0] = acc_cmd.value[ACC_HI_LSB-1:0];
      default: begin
        if (sw_acchi) begin
          next_acc[ACC_W-1:ACC_HI_LSB] = hwdata;
        end
        if (sw_acclo) begin
          next_acc[ACC_HI_LSB-1:0] = hwdata;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sixty_four_bit_sum_reg <= ACC_RESET;
    end else begin
      sixty_four_bit_sum_reg <= next_acc;
    end
  end

  assign read_sum_upper  = sixty_four_bit_sum_reg[ACC_W-1:ACC_HI_LSB];
  assign read_sum_middle =
    sixty_four_bit_sum_reg[ACC_MID_LSB+WORD_W-1:ACC_MID_LSB];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  spc_capture_a: assert property (fast_irq_take |=>
    saved_instruction_pointer == $past(instruction_pointer))
    else $error("saved pointer missed fast irq capture");

  ssw_capture_a: assert property (fast_irq_take |=>
    saved_status_word == $past(processor_status_word))
    else $error("saved status missed fast irq capture");

  fast_branch_a: assert property (fast_irq_take |=>
    instruction_pointer == $past(fast_irq_target))
    else $error("fast irq did not branch to target");

  saved_hold_a: assert property (!fast_irq_take && !sw_spc && !sw_ssw |=>
    $stable(saved_instruction_pointer) && $stable(saved_status_word))
    else $error("saved registers changed without cause");

  isp_write_a: assert property (sp_write && !user_sel && !sw_usp |=>
    interrupt_stack_ptr == $past(gpr_wr.data) && $stable(user_stack_ptr))
    else $error("register zero write missed interrupt stack");

  gpr_write_a: assert property (gpr_wr.en && gpr_wr.idx != SP_IDX |=>
    general_regs[$past(gpr_wr.idx)] == $past(gpr_wr.data))
    else $error("general register write lost");

  acc_product_a: assert property (acc_cmd.op == ACC_PRODUCT |=>
    sixty_four_bit_sum_reg == $past(acc_cmd.value))
    else $error("product did not overwrite accumulator");

  acc_half_a: assert property (acc_cmd.op == ACC_WR_HI |=>
    read_sum_upper == $past(acc_cmd.value[ACC_W-1:ACC_HI_LSB])
    && sixty_four_bit_sum_reg[ACC_HI_LSB-1:0] == $past(sixty_four_bit_sum_reg[ACC_HI_LSB-1:0]))
    else $error("upper write disturbed lower half");

  sequence hi_then_lo_s;
    (acc_cmd.op == ACC_WR_HI) ##1 (acc_cmd.op == ACC_WR_LO);
  endsequence

  acc_middle_a: assert property (hi_then_lo_s |=>
    read_sum_middle == {$past(acc_cmd.value[ACC_HI_LSB+ACC_MID_LSB-1:ACC_HI_LSB], 2),
                        $past(acc_cmd.value[ACC_HI_LSB-1:ACC_MID_LSB])})
    else $error("middle read wrong after two half writes");

  pc_update_a: assert property (pc_wr_en && !fast_irq_take |=>
    instruction_pointer == $past(pc_wr_data))
    else $error("instruction pointer not updated");

  // a bus write to the other stack pointer in the same cycle is legal
  usp_write_a: assert property (sp_write && user_sel && !sw_isp |=>
    user_stack_ptr == $past(gpr_wr.data) && $stable(interrupt_stack_ptr))
    else $error("register zero write missed user stack");

  acc_low_a: assert property (acc_cmd.op == ACC_WR_LO |=>
    sixty_four_bit_sum_reg[ACC_HI_LSB-1:0] == $past(acc_cmd.value[ACC_HI_LSB-1:0])
    && $stable(read_sum_upper))
    else $error("lower write disturbed upper half");

  psw_update_a: assert property (psw_wr_en |=>
    processor_status_word == $past(psw_wr_data))
    else $error("status word not updated");

  sp_operand_a: assert property (rd_b_idx == SP_IDX |->
    rd_b_data == stack_ptr)
    else $error("register zero read missed stack pointer");

  vec_fetch_a: assert property (vec_num == '0 |->
    vector_fetch_addr == vector_table_base)
    else $error("vector zero not at table base");

endmodule // crsfb_regset

// ==== sim/crsfb_exec_model.sv ====
// Purpose : execute-stage stand-in that drives the core ports of the register set
// Assumes : each call starts just after a rising edge and holds for one edge
// Notes   : data lines released after a command carry the inverse of their last value; enables, irq and op return to idle
`timescale 1ns/1ns
module crsfb_exec_model (
  input  wire logic                         clock,        // core clock
  output      logic [crsfb_pkg::IDX_W-1:0]  rd_a_idx,     // operand a select
  output      logic [crsfb_pkg::IDX_W-1:0]  rd_b_idx,     // operand b select
  output      crsfb_pkg::crsfb_gpr_wr_t     gpr_wr,       // result write
  output      logic                         psw_wr_en,    // status update
  output      logic [crsfb_pkg::WORD_W-1:0] psw_wr_data,  // new status
  output      logic                         pc_wr_en,     // next instruction
  output      logic [crsfb_pkg::WORD_W-1:0] pc_wr_data,   // its address
  output      logic                         fast_irq_take,// fast irq pulse
  output      logic [crsfb_pkg::VEC_W-1:0]  vec_num,      // vector number
  output      crsfb_pkg::crsfb_acc_cmd_t    acc_cmd       // accumulator command
);
  import crsfb_pkg::*;
  // ----------------------------------------------------------------
  // idle state at time zero
  // ----------------------------------------------------------------
  initial begin
    {rd_a_idx, rd_b_idx, vec_num} = '0;
    gpr_wr = '0;
    {psw_wr_en, psw_wr_data, pc_wr_en, pc_wr_data, fast_irq_take} = '0;
    acc_cmd = '{op: ACC_NONE, value: ACC_RESET};
  end
  // operand selects are levels, the decode stage just holds them
  task automatic sel(input logic [IDX_W-1:0] a, input logic [IDX_W-1:0] b, input logic [7:0] v);
    @(posedge clock);
    rd_a_idx <= a;
    rd_b_idx <= b;
    vec_num  <= v;
  endtask
  // the caller keeps stack pointer values word aligned
  task automatic put_gpr(input logic [IDX_W-1:0] i, input logic [WORD_W-1:0] d);
    @(posedge clock);
    gpr_wr <= '{en: 1'b1, idx: i, data: d};
    @(posedge clock);
    gpr_wr <= '{en: 1'b0, idx: ~i, data: ~d};
  endtask
  task automatic put_psw(input logic [WORD_W-1:0] d);
    @(posedge clock);
    psw_wr_en   <= 1'b1;
    psw_wr_data <= d;
    @(posedge clock);
    psw_wr_en   <= 1'b0;
    psw_wr_data <= ~d;
  endtask
  // irq set means the fast interrupt lands with a normal pc step in the same cycle
  task automatic put_pc(input logic [WORD_W-1:0] d, input logic irq);
    @(posedge clock);
    pc_wr_en      <= 1'b1;
    pc_wr_data    <= d;
    fast_irq_take <= irq;
    @(posedge clock);
    pc_wr_en      <= 1'b0;
    pc_wr_data    <= ~d;
    fast_irq_take <= 1'b0;
  endtask
  task automatic put_acc(input crsfb_acc_op_t op, input logic [ACC_W-1:0] v);
    @(posedge clock);
    acc_cmd <= '{op: op, value: v};
    @(posedge clock);
    acc_cmd <= '{op: ACC_NONE, value: ~v};
  endtask
  // two half writes on consecutive edges compose one 64-bit value
  task automatic put_acc_pair(input logic [WORD_W-1:0] hi, input logic [WORD_W-1:0] lo);
    @(posedge clock);
    acc_cmd <= '{op: ACC_WR_HI, value: {hi, hi}};
    @(posedge clock);
    acc_cmd <= '{op: ACC_WR_LO, value: {lo, lo}};
    @(posedge clock);
    acc_cmd <= '{op: ACC_NONE, value: {~lo, ~lo}};
  endtask
endmodule // crsfb_exec_model

// ==== sim/crsfb_regset_tb_top.sv ====
// Purpose : self-checking bench for the cpu register set
// Assumes : zero-wait slave, hready fed back from hreadyout
// Notes   : core commands come from the execute-stage model
`timescale 1ns/1ns
module crsfb_regset_tb_top;
  import crsfb_pkg::*;
  logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp, psw_wr_en, pc_wr_en;
  logic [31:0] haddr, hwdata, hrdata, v, rd_a_data, rd_b_data, stack_ptr, status, ip;
  logic [31:0] psw_wr_data, pc_wr_data, vfa, vtb, fit, sum_hi, sum_mid, sip, ssw;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  rd_a_idx, rd_b_idx;
  logic        fast_irq_take;
  logic [7:0]  vec_num;
  crsfb_gpr_wr_t  gpr_wr;
  crsfb_acc_cmd_t acc_cmd;
  int          fail_count, checked;
  logic [7:0]  offs [11] = '{OFF_PSW, OFF_PC, OFF_VTB, OFF_FIT, OFF_ISP, OFF_USP,
                              OFF_SPC, OFF_SSW, OFF_ACCHI, OFF_ACCLO, OFF_ACCMI};
  assign hready = hreadyout;
  // ----------------------------------------------------------------
  // design and execute-stage model
  // ----------------------------------------------------------------
  crsfb_regset crsfb_regset_inst (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rd_a_idx(rd_a_idx),
    .rd_a_data(rd_a_data), .rd_b_idx(rd_b_idx), .rd_b_data(rd_b_data), .gpr_wr(gpr_wr),
    .stack_ptr(stack_ptr), .psw_wr_en(psw_wr_en), .psw_wr_data(psw_wr_data),
    .processor_status_word(status), .pc_wr_en(pc_wr_en), .pc_wr_data(pc_wr_data),
    .instruction_pointer(ip), .fast_irq_take(fast_irq_take), .vec_num(vec_num),
    .vector_fetch_addr(vfa), .vector_table_base(vtb), .fast_irq_target(fit),
    .acc_cmd(acc_cmd), .read_sum_upper(sum_hi), .read_sum_middle(sum_mid),
    .saved_instruction_pointer(sip), .saved_status_word(ssw));
  crsfb_exec_model crsfb_exec_model_inst (.clock(clock), .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx), .gpr_wr(gpr_wr), .psw_wr_en(psw_wr_en), .psw_wr_data(psw_wr_data),
    .pc_wr_en(pc_wr_en), .pc_wr_data(pc_wr_data), .fast_irq_take(fast_irq_take),
    .vec_num(vec_num), .acc_cmd(acc_cmd));
  // ----------------------------------------------------------------
  // clock, compare and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask
  // wait for hready at a rising edge; only the watchdog ends a hung wait
  task automatic bus_wait();
    @(posedge clock);
    while (hready !== 1'b1) begin
      @(posedge clock);
    end
  endtask
  task automatic xfer(input logic [7:0] off, input logic wr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, off};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait();
    v = hrdata;  // read data is taken at the closing edge
    chk("response", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask
  task automatic rd(input string what, input logic [7:0] off, input logic [31:0] exp);
    xfer(off, 1'b0, ~exp);
    chk(what, exp, v);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {fail_count, checked} = '0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    // everything reads zero after reset, an unmapped word too
    foreach (offs[i]) rd("reset", offs[i], WORD_RESET);
    xfer(8'h40, 1'b1, 32'hFFFF_FFFF);
    rd("unmapped", 8'h40, 32'h0);
    // bus written control registers, stack pointers kept word aligned
    xfer(OFF_VTB, 1'b1, 32'h0001_0000);
    xfer(OFF_FIT, 1'b1, 32'h0000_8000);
    xfer(OFF_USP, 1'b1, 32'h2000_0040);
    rd("table base", OFF_VTB, 32'h0001_0000);
    rd("irq target", OFF_FIT, 32'h0000_8000);
    crsfb_exec_model_inst.sel(4'h0, 4'h0, 8'hFF);
    #1 chk("vector addr", 32'h0001_03FC, vfa);
    chk("table base port", 32'h0001_0000, vtb);
    chk("irq target port", 32'h0000_8000, fit);
    // all sixteen general registers, register zero through the interrupt stack
    for (int i = 0; i < 16; i++) crsfb_exec_model_inst.put_gpr(4'(i), 32'h1000_0000 + i * 4);
    for (int i = 0; i < 16; i++) begin
      crsfb_exec_model_inst.sel(4'(i), 4'(15 - i), 8'h00);
      #1 chk("operand a", 32'h1000_0000 + i * 4, rd_a_data);
      chk("operand b", 32'h1000_003C - i * 4, rd_b_data);
    end
    chk("stack", 32'h1000_0000, stack_ptr);
    rd("isp", OFF_ISP, 32'h1000_0000);
    // stack select moves register zero onto the user stack
    crsfb_exec_model_inst.put_psw(32'h1 << PSW_USER_BIT);
    #1 chk("status", 32'h0002_0000, status);
    chk("user stack", 32'h2000_0040, stack_ptr);
    crsfb_exec_model_inst.put_gpr(4'h0, 32'h2000_0080);
    #1 chk("r0 data", 32'h2000_0080, rd_b_data);
    rd("usp", OFF_USP, 32'h2000_0080);
    rd("isp kept", OFF_ISP, 32'h1000_0000);
    // fast interrupt landing on top of a normal pc step
    crsfb_exec_model_inst.put_pc(32'h0000_1234, 1'b0);
    #1 chk("ip", 32'h0000_1234, ip);
    crsfb_exec_model_inst.put_pc(32'h0000_1238, 1'b1);
    #1 chk("saved ip", 32'h0000_1234, sip);
    chk("saved status", 32'h0002_0000, ssw);
    chk("branch", 32'h0000_8000, ip);
    crsfb_exec_model_inst.put_pc(32'h0000_8004, 1'b0);
    crsfb_exec_model_inst.put_psw(32'h0000_0005);
    #1 chk("saved ip kept", 32'h0000_1234, sip);
    chk("saved st kept", 32'h0002_0000, ssw);
    rd("saved status", OFF_SSW, 32'h0002_0000);
    xfer(OFF_SPC, 1'b1, 32'h0000_5678);
    rd("saved ip wr", OFF_SPC, 32'h0000_5678);
    // accumulator halves, then a product overwriting both
    crsfb_exec_model_inst.put_acc_pair(32'hA1B2_C3D4, 32'h1122_3344);
    #1 chk("sum upper", 32'hA1B2_C3D4, sum_hi);
    chk("sum middle", 32'hC3D4_1122, sum_mid);
    crsfb_exec_model_inst.put_acc(ACC_WR_HI, {2{32'h0BAD_F00D}});
    rd("sum low kept", OFF_ACCLO, 32'h1122_3344);
    rd("sum mid bus", OFF_ACCMI, 32'hF00D_1122);
    crsfb_exec_model_inst.put_acc(ACC_PRODUCT, 64'h0123_4567_89AB_CDEF);
    #1 chk("product mid", 32'h4567_89AB, sum_mid);
    rd("product hi", OFF_ACCHI, 32'h0123_4567);
    rd("product lo", OFF_ACCLO, 32'h89AB_CDEF);
    // every writable word written over the bus and read back
    for (int i = 0; i < 10; i++) begin
      xfer(offs[i], 1'b1, 32'h0000_1000 + i * 4);
      rd("bus write", offs[i], 32'h0000_1000 + i * 4);
    end
    chk("ip port", 32'h0000_1004, ip);
    chk("status port", 32'h0000_1000, status);
    rd("bus sum mid", OFF_ACCMI, 32'h1020_0000);
    end_of_test();
  end
endmodule // crsfb_regset_tb_top
